// >>> hdl/lvi_pkg.sv
// Functional notes
// - Monitor enable bit powers the supply detector; zero switches it off; resets low.
// - Three-bit level field picks 2.0,2.2,2.4,2.7,3.0,3.3,3.6 or 4.0 volts.
// - Read-only detected bit is one while supply sits below the chosen level.
// - Sleep forces the detector off whatever its enable bit says.
// - Monitor request flag sets only after a fixed delay of continuous detection.
// - Monitor request wakes from idle; presetting its flag before idle avoids it.
// - Bandgap runs when detector, low-supply reset or buffer bit is on.
// - Top two bits of the monitor control register read zero.
// - Detected bit may chatter; nothing filters it beyond the request delay.
// - Monitor request is a sub-source of a multi-function request.
// - Every source has enable and flag; one global enable without a flag.
// - Four multi-function requests with primary bits, sub-sources in four registers.
// - Two external pins raise requests, each with enable and flag.
// - Pin b edge field, bits 3..2: off, rising, falling, both.
// - Pin a edge field, bits 1..0: off, rising, falling, both.
// - Top four bits of the edge select register read zero.
// - A set flag raises a request only with its enable bit set.
// - Global enable low blocks every request.
`default_nettype none
package lvi_pkg;

    //------------------------------------------------------------
    // Register indices on the data memory port
    //------------------------------------------------------------
    localparam int       NUM_REGS         = 9;
    localparam int       ADDR_W           = 4;
    localparam logic [3:0] IDX_LV_CTRL    = 4'h0;
    localparam logic [3:0] IDX_EDGE_SEL   = 4'h1;
    localparam logic [3:0] IDX_PRIM_0     = 4'h2;
    localparam logic [3:0] IDX_PRIM_1     = 4'h3;
    localparam logic [3:0] IDX_PRIM_2     = 4'h4;
    localparam logic [3:0] IDX_MULTI_0    = 4'h5;
    localparam logic [3:0] IDX_MULTI_1    = 4'h6;
    localparam logic [3:0] IDX_MULTI_2    = 4'h7;
    localparam logic [3:0] IDX_MULTI_3    = 4'h8;

    //------------------------------------------------------------
    // Field positions and reset value
    //------------------------------------------------------------
    localparam int         LVC_LEVEL_LSB  = 0;
    localparam int         LVC_BGAP_BIT   = 3;
    localparam int         LVC_EN_BIT     = 4;
    localparam int         LVC_DET_BIT    = 5;
    localparam int         ESEL_A_LSB     = 0;
    localparam int         ESEL_B_LSB     = 2;
    localparam int         FLAG_OFS       = 4;  // flag sits 4 above its enable
    localparam logic [7:0] REG_RESET      = 8'h00;

    // Writable bits; unimplemented and read-only bits stay out
    localparam logic [7:0] WR_MASK [NUM_REGS] = '{
        8'h1F, 8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h77, 8'h33};

    //------------------------------------------------------------
    // Primary vectors in priority order: register and enable bit
    //------------------------------------------------------------
    localparam int         NUM_VEC        = 11;
    localparam logic [3:0] VEC_REG [NUM_VEC] = '{
        4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3,
        4'h4, 4'h4, 4'h4, 4'h4};
    localparam logic [2:0] VEC_EN  [NUM_VEC] = '{
        3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h3,
        3'h0, 3'h1, 3'h2, 3'h3};
    // Flag bit of each vector; in the first register flags sit three
    // above their enables, since bit 0 is the flagless global enable
    localparam logic [2:0] VEC_FLG [NUM_VEC] = '{
        3'h4, 3'h5, 3'h6, 3'h4, 3'h5, 3'h6, 3'h7,
        3'h4, 3'h5, 3'h6, 3'h7};

    //------------------------------------------------------------
    // Encodings
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } lvi_edge_type;

    typedef enum logic [2:0] {
        TRIP_2V0 = 3'b000,
        TRIP_2V2 = 3'b001,
        TRIP_2V4 = 3'b010,
        TRIP_2V7 = 3'b011,
        TRIP_3V0 = 3'b100,
        TRIP_3V3 = 3'b101,
        TRIP_3V6 = 3'b110,
        TRIP_4V0 = 3'b111
    } lvi_trip_type;

    //------------------------------------------------------------
    // Timing
    //------------------------------------------------------------
    localparam int CLK_PERIOD_NS        = 40;
    localparam int MONITOR_IRQ_DELAY_NS = 15000;
    localparam int MONITOR_IRQ_DELAY_CYC =
        (MONITOR_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W                = 9;

endpackage
`default_nettype wire

// >>> hdl/lvi_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
// Edge selection down to a pin detector and its event back up
interface lvi_edge_if;
    logic [1:0] sel;
    logic       evt;
    modport ctl (output sel, input evt);
    modport det (input sel, output evt);
endinterface
`default_nettype wire

// >>> hdl/lvi_pin_edge.sv
`timescale 1ns/1ps
`default_nettype none
module lvi_pin_edge
    import lvi_pkg::*;
(
    // Clock and control
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Raw pin level
    input  wire logic pin_raw,
    // Selection and event
    lvi_edge_if.det   e
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic evt_q;
    logic evt_d;

    //------------------------------------------------------------
    // Edge decode
    //------------------------------------------------------------
    // Edge field decode
    always_comb begin
        unique case (e.sel)
            EDGE_RISE: evt_d = sync2_q & ~prev_q;
            EDGE_FALL: evt_d = ~sync2_q & prev_q;
            EDGE_BOTH: evt_d = sync2_q ^ prev_q;
            EDGE_OFF:  evt_d = 1'b0;
        endcase
    end

    // Two-stage synchroniser ahead of the edge compare
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            evt_q   <= 1'b0;
        end else if (ce) begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            evt_q   <= evt_d;
        end
    end

    assign e.evt = evt_q;

    chk_rise_gives_event: assert property (
        @(posedge clk) disable iff (rst)
        ce && e.sel == EDGE_RISE && sync2_q && !prev_q |=> evt_q)
        else $error("rising edge with rise select gave no event");
    chk_off_no_event: assert property (
        @(posedge clk) disable iff (rst)
        ce && e.sel == EDGE_OFF |=> !evt_q)
        else $error("event raised with edge detection off");
endmodule
`default_nettype wire

// >>> hdl/lvi_delay.sv
`timescale 1ns/1ps
`default_nettype none
module lvi_delay
    import lvi_pkg::*;
(
    // Clock and control
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Level to qualify and one-shot result
    input  wire logic level,
    output logic      fire
);
    logic [DLY_W-1:0] cnt_q;
    logic [DLY_W-1:0] cnt_d;
    logic             done_q;
    logic             done_d;
    logic             fire_q;
    logic             fire_d;

    //------------------------------------------------------------
    // Hold counter
    //------------------------------------------------------------
    // Any drop of the level restarts the wait: no other filtering
    always_comb begin
        cnt_d  = cnt_q;
        done_d = done_q;
        fire_d = 1'b0;
        if (!level) begin
            cnt_d  = '0;
            done_d = 1'b0;
        end else if (!done_q) begin
            if (cnt_q == DLY_W'(MONITOR_IRQ_DELAY_CYC - 1)) begin
                fire_d = 1'b1;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + DLY_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
            fire_q <= 1'b0;
        end else if (ce) begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
            fire_q <= fire_d;
        end
    end

    assign fire = fire_q;
endmodule
`default_nettype wire

// >>> hdl/lvi_lvd_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lvi_lvd_irq_ctrl
    import lvi_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Data memory port from the core
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              mem_wr,
    input  wire logic              mem_rd,
    input  wire logic [7:0]        mem_wdata,
    output logic      [7:0]        mem_rdata_q,
    // Core interrupt handshake and power modes
    input  wire logic              irq_ack,
    input  wire logic              sleep_mode,
    input  wire logic              idle_mode,
    output logic                   irq_req_q,
    output logic      [3:0]        irq_vec_q,
    output logic                   wake_q,
    // Analog supply monitor
    input  wire logic              low_supply_reset_en,
    input  wire logic              supply_cmp_raw,
    output logic                   supply_monitor_on_q,
    output logic      [2:0]        trip_level_select,
    output logic                   bandgap_on_q,
    // External pins
    input  wire logic              ext_irq_pin_a,
    input  wire logic              ext_irq_pin_b,
    // Same-clock source events, one-cycle pulses
    input  wire logic              touch_evt,
    input  wire logic              uart_evt,
    input  wire logic              adc_evt,
    input  wire logic              tbase0_evt,
    input  wire logic              tbase1_evt,
    input  wire logic [1:0]        multi0_src_evt,
    input  wire logic [3:0]        multi1_src_evt,
    input  wire logic [2:0]        multi2_src_evt,
    input  wire logic              eeprom_evt
);
    logic [7:0] reg_q [NUM_REGS];
    logic [7:0] reg_d [NUM_REGS];
    logic [7:0] set_v [NUM_REGS];
    logic [7:0] clr_v [NUM_REGS];
    logic [7:0] rdata_d;
    logic       cmp_sync1_q;
    logic       cmp_sync2_q;
    logic       low_supply_detected;
    logic       lvf_fire;
    logic       monitor_on_d;
    logic       bandgap_d;
    logic       wake_d;
    logic       irq_req_d;
    logic [3:0] irq_vec_d;
    logic [3:0] multi_cond;
    logic       global_irq_enable;

    lvi_edge_if pin_a_if ();
    lvi_edge_if pin_b_if ();

    //------------------------------------------------------------
    // External pin edge detectors
    //------------------------------------------------------------
    // Pin a takes bits 1..0 of the edge register
    assign pin_a_if.sel = reg_q[IDX_EDGE_SEL][ESEL_A_LSB +: 2];
    // Pin b takes bits 3..2 of the edge register
    assign pin_b_if.sel = reg_q[IDX_EDGE_SEL][ESEL_B_LSB +: 2];

    lvi_pin_edge u_pin_a (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .pin_raw (ext_irq_pin_a),
        .e       (pin_a_if.det)
    );

    lvi_pin_edge u_pin_b (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .pin_raw (ext_irq_pin_b),
        .e       (pin_b_if.det)
    );

    //------------------------------------------------------------
    // Supply monitor
    //------------------------------------------------------------
    // Comparator output crosses in through two flip-flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmp_sync1_q <= 1'b0;
            cmp_sync2_q <= 1'b0;
        end else if (ce) begin
            cmp_sync1_q <= supply_cmp_raw;
            cmp_sync2_q <= cmp_sync1_q;
        end
    end

    // Detected only while the detector is really running
    assign low_supply_detected = cmp_sync2_q & supply_monitor_on_q;

    // Level field goes straight to the comparator reference
    assign trip_level_select = reg_q[IDX_LV_CTRL][LVC_LEVEL_LSB +: 3];

    // Request waits for the detection to hold through the delay
    lvi_delay u_irq_delay (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .level (low_supply_detected),
        .fire  (lvf_fire)
    );

    // Power controls and idle wake
    always_comb begin
        monitor_on_d = reg_q[IDX_LV_CTRL][LVC_EN_BIT] & ~sleep_mode;
        // Bandgap follows any of its three users
        bandgap_d    = reg_q[IDX_LV_CTRL][LVC_EN_BIT]
                     | low_supply_reset_en
                     | reg_q[IDX_LV_CTRL][LVC_BGAP_BIT];
        // Only a fresh flag set wakes; a preset flag stays quiet
        wake_d       = idle_mode & lvf_fire
                     & ~reg_q[IDX_MULTI_3][FLAG_OFS];
    end

    //------------------------------------------------------------
    // Flag sources
    //------------------------------------------------------------
    // Multi-function flag follows its enabled sub-flags
    always_comb begin
        for (int m = 0; m < 4; m++) begin
            multi_cond[m] = |(reg_q[int'(IDX_MULTI_0) + m][7:4]
                            & reg_q[int'(IDX_MULTI_0) + m][3:0]);
        end
    end

    // Each source owns a flag bit set by hardware
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            set_v[r] = 8'h00;
        end
        // Pin events set their own flags
        set_v[IDX_PRIM_0][4] = pin_a_if.evt;
        set_v[IDX_PRIM_0][5] = pin_b_if.evt;
        set_v[IDX_PRIM_0][6] = touch_evt;
        set_v[IDX_PRIM_1][4] = uart_evt;
        set_v[IDX_PRIM_1][5] = multi_cond[0];
        set_v[IDX_PRIM_1][6] = multi_cond[1];
        set_v[IDX_PRIM_1][7] = adc_evt;
        set_v[IDX_PRIM_2][4] = multi_cond[2];
        set_v[IDX_PRIM_2][5] = tbase0_evt;
        set_v[IDX_PRIM_2][6] = tbase1_evt;
        set_v[IDX_PRIM_2][7] = multi_cond[3];
        set_v[IDX_MULTI_0][5:4] = multi0_src_evt;
        set_v[IDX_MULTI_1][7:4] = multi1_src_evt;
        set_v[IDX_MULTI_2][6:4] = multi2_src_evt;
        set_v[IDX_MULTI_3][5]   = eeprom_evt;
        // Monitor request lands in a multi-function sub-flag
        set_v[IDX_MULTI_3][4]   = lvf_fire;
    end

    //------------------------------------------------------------
    // Vector selection and acknowledge
    //------------------------------------------------------------
    assign global_irq_enable = reg_q[IDX_PRIM_0][0];

    // Lowest table entry wins; later entries wait their turn
    always_comb begin
        irq_req_d = 1'b0;
        irq_vec_d = 4'h0;
        for (int v = NUM_VEC - 1; v >= 0; v--) begin
            // Flag counts only with its enable bit set
            // Flag position from its own table, not a fixed offset
            if (reg_q[VEC_REG[v]][VEC_EN[v]]
                && reg_q[VEC_REG[v]][VEC_FLG[v]]) begin
                irq_req_d = 1'b1;
                irq_vec_d = 4'(v);
            end
        end
        irq_req_d = irq_req_d & global_irq_enable;
    end

    // Taking a vector clears its primary flag; sub-flags stay
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            clr_v[r] = 8'h00;
        end
        if (irq_ack && irq_req_q) begin
            clr_v[VEC_REG[irq_vec_q]][VEC_FLG[irq_vec_q]] = 1'b1;
        end
    end

    //------------------------------------------------------------
    // Register file
    //------------------------------------------------------------
    // Hardware set wins over a clearing write in the same cycle
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            reg_d[r] = reg_q[r];
            if (mem_wr && mem_addr == ADDR_W'(r)) begin
                reg_d[r] = (mem_wdata & WR_MASK[r])
                         | (reg_q[r] & ~WR_MASK[r]);
            end
            reg_d[r] = ((reg_d[r] & ~clr_v[r]) | set_v[r]) & WR_MASK[r];
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        rdata_d = mem_rdata_q;
        if (mem_rd) begin
            rdata_d = 8'h00;
            if (mem_addr < ADDR_W'(NUM_REGS)) begin
                rdata_d = reg_q[mem_addr] & WR_MASK[mem_addr];
            end
            if (mem_addr == IDX_LV_CTRL) begin
                rdata_d[LVC_DET_BIT] = low_supply_detected;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                reg_q[r] <= REG_RESET;
            end
            mem_rdata_q         <= 8'h00;
            irq_req_q           <= 1'b0;
            irq_vec_q           <= 4'h0;
            wake_q              <= 1'b0;
            supply_monitor_on_q <= 1'b0;
            bandgap_on_q        <= 1'b0;
        end else if (ce) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                reg_q[r] <= reg_d[r];
            end
            mem_rdata_q         <= rdata_d;
            irq_req_q           <= irq_req_d;
            irq_vec_q           <= irq_vec_d;
            wake_q              <= wake_d;
            supply_monitor_on_q <= monitor_on_d;
            bandgap_on_q        <= bandgap_d;
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    // Helper: cycles the detection has held without a break
    logic [DLY_W:0] hold_cnt_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_cnt_q <= '0;
        end else if (ce) begin
            hold_cnt_q <= low_supply_detected
                        ? hold_cnt_q + (DLY_W+1)'(1) : '0;
        end
    end

    sequence s_lvf_sets;
        ce && lvf_fire;
    endsequence

    chk_lv_ctrl_upper: assert property (
        @(posedge clk) disable iff (rst)
        ce && mem_rd && mem_addr == IDX_LV_CTRL |=> mem_rdata_q[7:6] == 2'b00)
        else $error("monitor control upper bits not zero");
    chk_edge_upper: assert property (
        @(posedge clk) disable iff (rst)
        ce && mem_rd && mem_addr == IDX_EDGE_SEL |=> mem_rdata_q[7:4] == 4'h0)
        else $error("edge select upper bits not zero");
    chk_sleep_forces_off: assert property (
        @(posedge clk) disable iff (rst)
        ce && sleep_mode |=> !supply_monitor_on_q)
        else $error("detector running during sleep");
    chk_enable_turns_on: assert property (
        @(posedge clk) disable iff (rst)
        ce && !sleep_mode && reg_q[IDX_LV_CTRL][LVC_EN_BIT]
        |=> supply_monitor_on_q)
        else $error("detector off although enabled");
    chk_bandgap_users: assert property (
        @(posedge clk) disable iff (rst)
        ce && (low_supply_reset_en || reg_q[IDX_LV_CTRL][LVC_BGAP_BIT])
        |=> bandgap_on_q)
        else $error("bandgap off with a user active");
    chk_lvf_delay: assert property (
        @(posedge clk) disable iff (rst)
        s_lvf_sets |-> hold_cnt_q == (DLY_W+1)'(MONITOR_IRQ_DELAY_CYC))
        else $error("monitor flag set before the delay ran out");
    chk_lvf_flag_set: assert property (
        @(posedge clk) disable iff (rst)
        s_lvf_sets |=> reg_q[IDX_MULTI_3][4])
        else $error("monitor sub-flag not set");
    chk_global_blocks: assert property (
        @(posedge clk) disable iff (rst)
        ce && !global_irq_enable |=> !irq_req_q)
        else $error("request raised with global enable low");
    chk_enable_gates: assert property (
        @(posedge clk) disable iff (rst)
        ce && reg_q[IDX_PRIM_0][1] && reg_q[IDX_PRIM_0][4]
        && global_irq_enable |=> irq_req_q && irq_vec_q == 4'h0)
        else $error("enabled pin a flag gave no request");
    chk_multi_collect: assert property (
        @(posedge clk) disable iff (rst)
        ce && multi_cond[3] |=> reg_q[IDX_PRIM_2][7])
        else $error("multi-function flag missed an enabled sub-flag");

    // Taking pin a with no new event or write in the same cycle
    sequence s_pin_a_taken;
        ce && irq_ack && irq_req_q && irq_vec_q == 4'h0
        && !pin_a_if.evt && !mem_wr;
    endsequence

    chk_wake_idle: assert property (
        @(posedge clk) disable iff (rst)
        ce && !idle_mode |=> !wake_q)
        else $error("wake pulse outside idle");
    chk_preset_quiet: assert property (
        @(posedge clk) disable iff (rst)
        ce && reg_q[IDX_MULTI_3][FLAG_OFS] |=> !wake_q)
        else $error("wake pulse with monitor flag preset");
    chk_ack_clears: assert property (
        @(posedge clk) disable iff (rst)
        s_pin_a_taken |=> !reg_q[IDX_PRIM_0][4])
        else $error("taken pin a flag not cleared");
    chk_pin_flag_sets: assert property (
        @(posedge clk) disable iff (rst)
        ce && pin_a_if.evt |=> reg_q[IDX_PRIM_0][4])
        else $error("pin a event set no flag");
    chk_det_off_zero: assert property (
        @(posedge clk) disable iff (rst)
        ce && mem_rd && mem_addr == IDX_LV_CTRL && !supply_monitor_on_q
        |=> !mem_rdata_q[LVC_DET_BIT])
        else $error("detected bit high with detector off");
    chk_sub_flag_held: assert property (
        @(posedge clk) disable iff (rst)
        ce && !mem_wr && reg_q[IDX_MULTI_3][FLAG_OFS]
        |=> reg_q[IDX_MULTI_3][FLAG_OFS])
        else $error("monitor sub-flag lost without a write");
endmodule
`default_nettype wire

// >>> verif/lvi_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side: takes the pending vector with a one-cycle acknowledge
module lvi_core_model #(
    parameter int GAP = 3  // Idle cycles after a take, as a slow core
)(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Request from the controller
    input  wire logic       irq_req_q,
    input  wire logic [3:0] irq_vec_q,
    input  wire logic       ack_en,
    // Acknowledge and record of takes
    output logic            irq_ack,
    output logic [3:0]      last_vec,
    output var int          acks
);
    int gap;
    // The gap lets a taken request drop before it is looked at again
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_ack <= 1'b0;
            last_vec <= 4'h0;
            acks <= 0;
            gap <= 0;
        end else begin
            irq_ack <= 1'b0;
            if (gap > 0) begin
                gap <= gap - 1;
            end else if (ack_en && irq_req_q === 1'b1) begin
                irq_ack <= 1'b1;
                last_vec <= irq_vec_q;
                acks <= acks + 1;
                gap <= GAP;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/test_lvi_lvd_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_lvi_lvd_irq_ctrl;
    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] msk;
        logic [7:0] evf;
    } lvi_row_type;
    // Index, writable-bit readback, flags set by one burst of all events
    lvi_row_type rows [11] = '{
        '{4'h0, 8'h1F, 8'h00}, '{4'h1, 8'h0F, 8'h00}, '{4'h2, 8'h7F, 8'h40},
        '{4'h3, 8'hFF, 8'h90}, '{4'h4, 8'hFF, 8'h60}, '{4'h5, 8'h33, 8'h30},
        '{4'h6, 8'hFF, 8'hF0}, '{4'h7, 8'h77, 8'h70}, '{4'h8, 8'h33, 8'h20},
        '{4'h9, 8'h00, 8'h00}, '{4'hF, 8'h00, 8'h00}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [7:0]  wdat = 8'h00;
    logic        sleep_mode = 1'b0;
    logic        idle_mode = 1'b0;
    logic        lsr_en = 1'b0;
    logic        cmp = 1'b0;
    logic [1:0]  pin = 2'b00;
    logic [14:0] ev = 15'h0000;
    logic        ack_en = 1'b0;
    logic        ce = 1'b1;
    logic        ack, req, wake_q, mon_on, bgap;
    logic [3:0]  vec, last_vec;
    logic [7:0]  rdata, v;
    logic [2:0]  lvl;
    int          acks, n, fails = 0, cmp_count = 0, cyc = 0, wakes = 0;

    lvi_lvd_irq_ctrl i_dut (
        .clk(clk), .rst(rst), .ce(ce),
        .mem_addr(addr), .mem_wr(wr_s), .mem_rd(rd_s),
        .mem_wdata(wdat), .mem_rdata_q(rdata),
        .irq_ack(ack), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
        .irq_req_q(req), .irq_vec_q(vec), .wake_q(wake_q),
        .low_supply_reset_en(lsr_en), .supply_cmp_raw(cmp),
        .supply_monitor_on_q(mon_on), .trip_level_select(lvl),
        .bandgap_on_q(bgap),
        .ext_irq_pin_a(pin[0]), .ext_irq_pin_b(pin[1]),
        .touch_evt(ev[0]), .uart_evt(ev[1]), .adc_evt(ev[2]),
        .tbase0_evt(ev[3]), .tbase1_evt(ev[4]),
        .multi0_src_evt(ev[6:5]), .multi1_src_evt(ev[10:7]),
        .multi2_src_evt(ev[13:11]), .eeprom_evt(ev[14]));

    lvi_core_model i_core (
        .clk(clk), .rst(rst), .irq_req_q(req), .irq_vec_q(vec),
        .ack_en(ack_en), .irq_ack(ack), .last_vec(last_vec), .acks(acks));

    // Clock, hang guard and wake pulse count
    initial forever #20 clk = ~clk;
    always @(negedge clk) begin
        cyc++;
        if (wake_q === 1'b1) wakes++;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish;
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobes rise and fall on falling edges, one cycle each
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdat = d;
        wr_s = 1'b1;
        @(negedge clk);
        wr_s = 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk);
        rd_s = 1'b0;
        chk("register", rdata, exp);
    endtask
    // Multi registers first, so no level-set primary flag survives
    task automatic clr;
        for (int i = 10; i >= 0; i--) wr(rows[i].idx, 8'h00);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            rdc(rows[i].idx, 8'h00);
            wr(rows[i].idx, 8'hFF);
            rdc(rows[i].idx, rows[i].msk);
        end
        clr();
        @(negedge clk);
        ev = '1;
        @(negedge clk);
        ev = '0;
        foreach (rows[i]) rdc(rows[i].idx, rows[i].evf);
        clr();
        // Every edge code on both pins, taken by the core model
        ack_en = 1'b1;
        wr(4'h2, 8'h07);
        for (int p = 0; p < 2; p++) for (int s = 0; s < 4; s++) begin
            n = acks;
            wr(4'h1, 8'(s << (2 * p)));
            pin[p] = 1'b1;
            repeat (12) @(negedge clk);
            pin[p] = 1'b0;
            repeat (12) @(negedge clk);
            chk("takes", 8'(acks - n), 8'(s % 2 + s / 2));
            if (s != 0) chk("vector", {4'h0, last_vec}, 8'(p));
        end
        // Flag without enable, then enable without global
        wr(4'h1, 8'h01);
        wr(4'h2, 8'h01);
        pin[0] = 1'b1;
        repeat (12) @(negedge clk);
        rdc(4'h2, 8'h11);
        wr(4'h2, 8'h12);
        repeat (4) @(negedge clk);
        chk("request", {7'h0, req}, 8'h00);
        n = acks;
        wr(4'h2, 8'h13);
        repeat (10) @(negedge clk);
        chk("takes", 8'(acks - n), 8'h01);
        wr(4'h2, 8'h00);
        // Monitor at top level, idle, sub-enable on, primary enable off
        idle_mode = 1'b1;
        wr(4'h8, 8'h01);
        wr(4'h0, 8'h17);
        repeat (4) @(negedge clk);
        chk("level", {5'h0, lvl}, 8'h07);
        chk("power", {6'h0, mon_on, bgap}, 8'h03);
        // Settle time before the detected bit is trusted
        cmp = 1'b1;
        repeat (4) @(negedge clk);
        rdc(4'h0, 8'h37);
        repeat (350) @(negedge clk);
        rdc(4'h8, 8'h01);
        repeat (30) @(negedge clk);
        rdc(4'h8, 8'h11);
        rdc(4'h4, 8'h80);
        chk("wakes", 8'(wakes), 8'h01);
        sleep_mode = 1'b1;
        repeat (4) @(negedge clk);
        rdc(4'h0, 8'h17);
        chk("asleep", {7'h0, mon_on}, 8'h00);
        sleep_mode = 1'b0;
        // Bandgap users one at a time: buffer bit, reset, none
        for (int k = 0; k < 3; k++) begin
            wr(4'h0, (k == 0) ? 8'h08 : 8'h00);
            lsr_en = (k == 1);
            repeat (3) @(negedge clk);
            chk("bandgap", {7'h0, bgap}, 8'(k < 2));
        end
        // Software preset flag keeps the next fire quiet
        wr(4'h8, 8'h11);
        wr(4'h0, 8'h10);
        repeat (400) @(negedge clk);
        chk("quiet", 8'(wakes), 8'h01);
        // Clock enable low must freeze the register file
        ce = 1'b0;
        wr(4'h1, 8'h03);
        ce = 1'b1;
        rdc(4'h1, 8'h01);
        tally_and_finish;
    end
endmodule
`default_nettype wire
